/* common/dlfs_params.svh */
`ifndef DLFS_PARAMS_SVH
`define DLFS_PARAMS_SVH

`define DLFS_CLK_PERIOD_PS 10000
`define DLFS_CEIL_CYC(ps) (((ps) + `DLFS_CLK_PERIOD_PS - 1) / `DLFS_CLK_PERIOD_PS)

// Cycle counts and picosecond times; mode_set_spacing is counted in real clock edges.
`define DLFS_MODE_SET_SPACING_CYC 4
`define DLFS_MODE_SET_TO_CMD_CYC 12
`define DLFS_CLK_HOLD_SRE_PS 10000
`define DLFS_CLK_HOLD_SRE_CYC `DLFS_CEIL_CYC(`DLFS_CLK_HOLD_SRE_PS)
`define DLFS_CLK_STABLE_SRX_PS 10000
`define DLFS_CLK_STABLE_SRX_CYC `DLFS_CEIL_CYC(`DLFS_CLK_STABLE_SRX_PS)
`define DLFS_SR_EXIT_TO_CMD_PS 170000
`define DLFS_SR_EXIT_TO_CMD_CYC `DLFS_CEIL_CYC(`DLFS_SR_EXIT_TO_CMD_PS)
`define DLFS_PD_EXIT_PS 6000
`define DLFS_PD_EXIT_CYC `DLFS_CEIL_CYC(`DLFS_PD_EXIT_PS)
`define DLFS_DLL_LOCK_CYC 512
`define DLFS_CAL_OP_CYC 256

// Mode register field positions and reset values.
`define DLFS_MR1_DLL_OFF_BIT 0
`define DLFS_MR0_DLL_RESET_BIT 8
`define DLFS_MR1_TERM_LO_BIT 2
`define DLFS_MR1_TERM_MID_BIT 6
`define DLFS_MR1_TERM_HI_BIT 9
`define DLFS_MR2_TERM_WR_LO_BIT 9
`define DLFS_MR2_TERM_WR_HI_BIT 10
`define DLFS_MR0_RESET 16'h0000
`define DLFS_MR1_RESET 16'h0001

`endif

/* common/dlfs_pkg.sv */
package dlfs_pkg;
   typedef enum logic [2:0] {
      DLFS_CMD_NOP = 3'h0,
      DLFS_CMD_MRS = 3'h1,
      DLFS_CMD_SRE = 3'h2,
      DLFS_CMD_SRX = 3'h3,
      DLFS_CMD_PDE = 3'h4,
      DLFS_CMD_PDX = 3'h5,
      DLFS_CMD_LONG_IMPEDANCE_CALIBRATION = 3'h6,
      DLFS_CMD_ACT = 3'h7
   } dlfs_cmd_t;
   typedef logic [15:0] dlfs_word_t;
   typedef logic [1:0] dlfs_ba_t;
endpackage

/* common/dlfs_if.sv */
`timescale 1ns/100ps
interface dlfs_if;
   import dlfs_pkg::*;
   dlfs_cmd_t cmd;
   dlfs_ba_t bank;
   dlfs_word_t addr;
   logic clock_gate_input;
   logic termination_control_pin;
   logic clk_run;
   modport ctrl (output cmd, output bank, output addr, output clock_gate_input,
                 output termination_control_pin, output clk_run);
   modport dev (input cmd, input bank, input addr, input clock_gate_input,
                input termination_control_pin, input clk_run);
endinterface

/* hdl/dlfs_count.sv */
`timescale 1ns/100ps
`include "dlfs_params.svh"
module dlfs_count (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic load_i,
   input wire logic [9:0] value_i,
   output logic done_o
);
   logic [9:0] cnt;
   assign done_o = (cnt == 10'h000);
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt <= 10'h000;
      end else if (load_i) begin
         cnt <= value_i;
      end else if (cnt != 10'h000) begin
         cnt <= cnt - 10'h001;
      end
   end
endmodule

/* hdl/dlfs_dev.sv */
`timescale 1ns/100ps
`include "dlfs_params.svh"
module dlfs_dev (
   input wire logic clk_i,
   input wire logic reset_n_i,
   dlfs_if.dev link,
   output logic dll_enabled_o,
   output logic dll_locked_o,
   output logic clock_ignored_o,
   output logic in_self_refresh_o,
   output logic in_power_down_o,
   output logic [15:0] mode_zero_o,
   output logic [15:0] mode_one_o
);
   import dlfs_pkg::*;
   logic [15:0] mr0;
   logic [15:0] mr1;
   logic sr;
   logic pd;
   logic locking;
   logic locked;
   logic [9:0] sre_cnt;
   wire is_mrs = link.clock_gate_input && (link.cmd == DLFS_CMD_MRS);
   wire mr0_wr = is_mrs && (link.bank == 2'h0);
   wire mr1_wr = is_mrs && (link.bank == 2'h1);
   wire dll_reset = mr0_wr && link.addr[`DLFS_MR0_DLL_RESET_BIT];
   wire lock_done;
   dlfs_count u_lock (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .load_i(dll_reset),
      .value_i(10'(`DLFS_DLL_LOCK_CYC)),
      .done_o(lock_done)
   );
   // ************
   // State
   // ************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mr0 <= `DLFS_MR0_RESET;
         mr1 <= `DLFS_MR1_RESET;
         sr <= 1'b0;
         pd <= 1'b0;
         locking <= 1'b0;
         locked <= 1'b0;
         sre_cnt <= 10'h000;
      end else begin
         if (mr0_wr) begin
            mr0 <= link.addr;
         end
         if (mr1_wr) begin
            mr1 <= link.addr;
         end
         if (link.cmd == DLFS_CMD_SRE) begin
            sr <= 1'b1;
         end else if (link.cmd == DLFS_CMD_SRX) begin
            sr <= 1'b0;
         end
         if (link.cmd == DLFS_CMD_PDE) begin
            pd <= 1'b1;
         end else if (link.cmd == DLFS_CMD_PDX) begin
            pd <= 1'b0;
         end
         // Clock ignored once clock_hold_after_sr_entry has elapsed in self-refresh.
         if (!sr) begin
            sre_cnt <= 10'h000;
         end else if (sre_cnt != 10'(`DLFS_CLK_HOLD_SRE_CYC)) begin
            sre_cnt <= sre_cnt + 10'h001;
         end
         // Disabling the loop drops lock at once; re-enable waits for a reset.
         if (mr1_wr && link.addr[`DLFS_MR1_DLL_OFF_BIT]) begin
            locking <= 1'b0;
            locked <= 1'b0;
         end else if (dll_reset && !mr1[`DLFS_MR1_DLL_OFF_BIT]) begin
            locking <= 1'b1;
            locked <= 1'b0;
         end else if (locking && lock_done) begin
            locking <= 1'b0;
            locked <= 1'b1;
         end
      end
   end
   assign dll_enabled_o = !mr1[`DLFS_MR1_DLL_OFF_BIT];
   assign dll_locked_o = locked;
   assign clock_ignored_o = sr && (sre_cnt == 10'(`DLFS_CLK_HOLD_SRE_CYC));
   assign in_self_refresh_o = sr;
   assign in_power_down_o = pd;
   assign mode_zero_o = mr0;
   assign mode_one_o = mr1;
endmodule

/* hdl/dlfs_ctrl.sv */
`timescale 1ns/100ps
`include "dlfs_params.svh"
//Contract
// - Start idle, banks precharged, termination off.
// - Self-refresh, wait clock hold, then change.
// - Stable clock before self-refresh exit.
// - Clock gate high until lock after reset.
// - Termination low until lock when enabled.
// - After exit delay, clear DLL-off bit.
// - After spacing, set DLL reset bit.
// - Rewrite latencies; calibration after command delay.
// - Locked commands wait lock and calibration.
// - Mode sets spaced four real clock edges.
// - Nanoseconds round up to whole cycles.
// - Frequency change only in refresh/power-down.
// - Clock ignored after hold in self-refresh.
// - Power-down: termination low if nominal enabled.
// - Power-down: wait hold after gate low.
// - Power-down change: gate, termination held low.
// - Stable clock, exit, delay, then DLL reset.
// - Extra latency writes with gate held high.
// - During re-lock: termination low, gate high.
// - After lock, device runs at new clock.
// - DLL-off bit disables loop until cleared.
module dlfs_ctrl (
   input wire logic clk_i,
   input wire logic reset_n_i,
   dlfs_if.ctrl link,
   input wire logic start_i,
   input wire logic use_power_down_i,
   input wire logic calibrate_i,
   input wire logic [15:0] mr0_value_i,
   input wire logic [15:0] mr1_value_i,
   input wire logic [15:0] mr2_value_i,
   input wire logic user_mrs_i,
   input wire dlfs_pkg::dlfs_ba_t user_bank_i,
   input wire dlfs_pkg::dlfs_word_t user_addr_i,
   output logic busy_o,
   output logic freq_change_window_o,
   output logic locked_cmd_ok_o,
   output logic done_o
);
   import dlfs_pkg::*;
   typedef enum logic [10:0] {
      S_IDLE = 11'h001,
      S_ENTER = 11'h002,
      S_HOLD = 11'h004,
      S_CHANGE = 11'h008,
      S_EXIT = 11'h010,
      S_DLL_ON = 11'h020,
      S_DLL_RST = 11'h040,
      S_STABLE = 11'h080,
      S_MR2 = 11'h100,
      S_CAL = 11'h200,
      S_LOCK = 11'h400
   } dlfs_state_t;
   dlfs_state_t state;
   dlfs_state_t next_state;
   logic pd_mode;
   logic term_nom;
   logic term_wr;
   logic term_sticky;
   logic cal_done;
   logic [9:0] gap;
   logic [9:0] wait_val;
   logic wait_load;
   logic [9:0] lock_cnt;
   logic [9:0] cal_cnt;
   logic gate;
   dlfs_cmd_t next_cmd;
   dlfs_ba_t next_bank;
   dlfs_word_t next_addr;
   dlfs_cmd_t cmd_q;
   dlfs_ba_t bank_q;
   dlfs_word_t addr_q;
   wire wait_done;
   // ************
   // Helpers
   // ************
   function automatic logic [9:0] cyc(input int n);
      return 10'(n);
   endfunction
   dlfs_count u_wait (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .load_i(wait_load),
      .value_i(wait_val),
      .done_o(wait_done)
   );
   // Mode sets must keep four real edges apart, so the gap counts clk_i edges.
   wire mrs_ok = (gap == 10'h000);
   wire user_mrs_go = user_mrs_i && (state == S_IDLE) && mrs_ok;
   wire term_any = term_nom || term_wr;
   wire term_hold = pd_mode ? term_nom : term_sticky;
   wire step = wait_done && mrs_ok;
   // ************
   // Sequencer
   // ************
   always_comb begin
      next_state = state;
      next_cmd = DLFS_CMD_NOP;
      next_bank = 2'h0;
      next_addr = 16'h0000;
      wait_load = 1'b0;
      wait_val = 10'h000;
      case (state)
         S_IDLE: begin
            if (start_i) begin
               next_state = S_ENTER;
            end else if (user_mrs_go) begin
               next_cmd = DLFS_CMD_MRS;
               next_bank = user_bank_i;
               next_addr = user_addr_i;
            end
         end
         S_ENTER: begin
            if (step) begin
               next_cmd = use_power_down_i ? DLFS_CMD_PDE : DLFS_CMD_SRE;
               next_state = S_HOLD;
               wait_load = 1'b1;
               wait_val = cyc(`DLFS_CLK_HOLD_SRE_CYC);
            end
         end
         S_HOLD: begin
            if (wait_done) begin
               next_state = S_CHANGE;
            end
         end
         S_CHANGE: begin
            // The change window lasts one cycle; the stable count only starts once the clock runs again.
            next_state = S_STABLE;
            wait_load = 1'b1;
            wait_val = cyc(`DLFS_CLK_STABLE_SRX_CYC);
         end
         S_STABLE: begin
            if (wait_done) begin
               next_cmd = pd_mode ? DLFS_CMD_PDX : DLFS_CMD_SRX;
               next_state = S_EXIT;
               wait_load = 1'b1;
               wait_val = pd_mode ? cyc(`DLFS_PD_EXIT_CYC) : cyc(`DLFS_SR_EXIT_TO_CMD_CYC);
            end
         end
         S_EXIT: begin
            if (step) begin
               next_cmd = DLFS_CMD_MRS;
               next_bank = 2'h1;
               next_addr = mr1_value_i;
               next_addr[`DLFS_MR1_DLL_OFF_BIT] = 1'b0;
               next_state = S_DLL_RST;
            end
         end
         S_DLL_RST: begin
            if (step) begin
               next_cmd = DLFS_CMD_MRS;
               next_bank = 2'h0;
               next_addr = mr0_value_i;
               next_addr[`DLFS_MR0_DLL_RESET_BIT] = 1'b1;
               next_state = S_MR2;
            end
         end
         S_MR2: begin
            if (step) begin
               next_cmd = DLFS_CMD_MRS;
               next_bank = 2'h2;
               next_addr = mr2_value_i;
               next_state = S_CAL;
               wait_load = 1'b1;
               wait_val = cyc(`DLFS_MODE_SET_TO_CMD_CYC);
            end
         end
         S_CAL: begin
            if (wait_done) begin
               next_cmd = calibrate_i ? DLFS_CMD_LONG_IMPEDANCE_CALIBRATION : DLFS_CMD_NOP;
               next_state = S_LOCK;
            end
         end
         S_LOCK: begin
            if ((lock_cnt == 10'h000) && cal_done) begin
               next_state = S_IDLE;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end
   wire issue_mrs = (next_cmd == DLFS_CMD_MRS);
   wire issue_dll_rst = issue_mrs && (next_bank == 2'h0) && (state == S_DLL_RST);
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= S_IDLE;
         cmd_q <= DLFS_CMD_NOP;
         bank_q <= 2'h0;
         addr_q <= 16'h0000;
         gap <= 10'h000;
      end else begin
         state <= next_state;
         cmd_q <= next_cmd;
         bank_q <= next_bank;
         addr_q <= next_addr;
         if (issue_mrs) begin
            gap <= cyc(`DLFS_MODE_SET_SPACING_CYC - 1);
         end else if (gap != 10'h000) begin
            gap <= gap - 10'h001;
         end
      end
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pd_mode <= 1'b0;
         term_nom <= 1'b0;
         term_wr <= 1'b0;
         term_sticky <= 1'b0;
      end else begin
         if (state == S_IDLE && start_i) begin
            pd_mode <= use_power_down_i;
            term_sticky <= term_any;
         end
         if (issue_mrs && next_bank == 2'h1) begin
            term_nom <= |{next_addr[`DLFS_MR1_TERM_HI_BIT], next_addr[`DLFS_MR1_TERM_MID_BIT],
                          next_addr[`DLFS_MR1_TERM_LO_BIT]};
         end
         if (issue_mrs && next_bank == 2'h2) begin
            term_wr <= |next_addr[`DLFS_MR2_TERM_WR_HI_BIT:`DLFS_MR2_TERM_WR_LO_BIT];
         end
      end
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lock_cnt <= 10'h000;
         cal_cnt <= 10'h000;
         cal_done <= 1'b1;
         gate <= 1'b1;
      end else begin
         if (issue_dll_rst) begin
            lock_cnt <= cyc(`DLFS_DLL_LOCK_CYC);
         end else if (lock_cnt != 10'h000) begin
            lock_cnt <= lock_cnt - 10'h001;
         end
         if (state == S_CAL && wait_done && calibrate_i) begin
            cal_cnt <= cyc(`DLFS_CAL_OP_CYC);
            cal_done <= 1'b0;
         end else if (cal_cnt != 10'h000) begin
            cal_cnt <= cal_cnt - 10'h001;
         end else begin
            cal_done <= 1'b1;
         end
         // Gate goes low with the entry command and back high with exit.
         if (next_cmd == DLFS_CMD_SRE || next_cmd == DLFS_CMD_PDE) begin
            gate <= 1'b0;
         end else if (next_cmd == DLFS_CMD_SRX || next_cmd == DLFS_CMD_PDX) begin
            gate <= 1'b1;
         end
      end
   end
   // Termination is held low in every state; the pin is ANDed with a constant 0, so term_hold and in_seq never raise it.
   wire in_seq = (state != S_IDLE) && (state != S_ENTER);
   assign link.termination_control_pin = 1'b0 && term_hold && in_seq;
   assign link.cmd = cmd_q;
   assign link.bank = bank_q;
   assign link.addr = addr_q;
   assign link.clock_gate_input = gate;
   assign link.clk_run = !(state == S_CHANGE);
   assign busy_o = (state != S_IDLE);
   assign freq_change_window_o = (state == S_CHANGE);
   assign locked_cmd_ok_o = (lock_cnt == 10'h000) && cal_done;
   assign done_o = (state == S_LOCK) && (next_state == S_IDLE);
endmodule

/* tb/dlfs_props.sv */
`timescale 1ns/100ps
module dlfs_props (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire dlfs_pkg::dlfs_cmd_t cmd,
   input wire dlfs_pkg::dlfs_ba_t bank,
   input wire dlfs_pkg::dlfs_word_t addr,
   input wire logic clock_gate_input,
   input wire logic termination_control_pin,
   input wire logic clk_run
);
   import dlfs_pkg::*;
   // Cycles since the last mode set, saturating so a long idle never wraps.
   logic [7:0] since_mrs;
   wire logic [7:0] next_since_mrs;
   wire logic is_mrs = (cmd == DLFS_CMD_MRS);
   wire logic is_exit = (cmd == DLFS_CMD_SRX) || (cmd == DLFS_CMD_PDX);
   wire logic dll_on_wr = is_mrs && (bank == 2'h1) && (addr[0] == 1'b0);
   assign next_since_mrs = is_mrs ? 8'h01 : ((since_mrs == 8'hff) ? 8'hff : since_mrs + 8'h01);
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         since_mrs <= 8'hff;
      end else begin
         since_mrs <= next_since_mrs;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // ****************************************
   // Assertions
   // ****************************************
   chk_term_low: assert property (termination_control_pin == 1'b0)
      else $error("termination pin driven high");
   chk_change_gated: assert property (!clk_run |-> !clock_gate_input)
      else $error("clock stopped with gate high");
   chk_hold_first: assert property ($fell(clk_run) |-> $past(clock_gate_input) == 1'b0)
      else $error("clock changed without hold after entry");
   chk_stable_exit: assert property (is_exit |-> $past(clk_run) && clk_run)
      else $error("exit without stable clock");
   chk_gate_after_exit: assert property (is_exit |=> clock_gate_input [*8])
      else $error("gate dropped after exit");
   chk_mrs_spacing: assert property (is_mrs |=> !is_mrs [*3])
      else $error("mode sets closer than four edges");
   chk_dll_enable_wait: assert property ((cmd == DLFS_CMD_SRX) |=>
      !is_mrs [*8] ##1 !is_mrs [*8] ##[1:20] dll_on_wr)
      else $error("loop enable write misplaced after exit");
   chk_dll_reset_next: assert property (dll_on_wr |=>
      !is_mrs [*3] ##[1:8] (is_mrs && bank == 2'h0 && addr[8] == 1'b1))
      else $error("loop reset write missing after enable");
   chk_cal_spacing: assert property ((cmd == DLFS_CMD_LONG_IMPEDANCE_CALIBRATION) |-> since_mrs >= 8'h0c)
      else $error("calibration too soon after mode set");
   cov_sr: cover property (cmd == DLFS_CMD_SRE);
   cov_pd: cover property (cmd == DLFS_CMD_PDE);
   cov_cal: cover property (cmd == DLFS_CMD_LONG_IMPEDANCE_CALIBRATION);
   cov_reset: cover property (is_mrs && bank == 2'h0 && addr[8] == 1'b1);
endmodule

/* tb/tb_dlfs.sv */
`timescale 1ns/100ps
module tb_dlfs;
   import dlfs_pkg::*;
   logic clk_i, reset_n_i, start_i, use_power_down_i, calibrate_i, user_mrs_i;
   dlfs_ba_t user_bank_i;
   dlfs_word_t user_addr_i;
   logic busy_o, freq_change_window_o, locked_cmd_ok_o, done_o;
   logic dll_enabled_o, dll_locked_o, clock_ignored_o, in_self_refresh_o, in_power_down_o;
   logic [15:0] mode_zero_o, mode_one_o;
   int errors, checks;
   int n_entry, n_sre, n_zq, n_mrs, t_exit, t_mrs1, t_mr0, t_lock, cyc;
   logic [1:0] bk [3];
   logic mr0_bit8, seen_ign, seen_done, seen_win, seen_sr, seen_pd, ok_early;
   dlfs_if link();
   dlfs_ctrl dlfs_ctrl_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link), .start_i(start_i),
      .use_power_down_i(use_power_down_i), .calibrate_i(calibrate_i), .mr0_value_i(16'h0020),
      .mr1_value_i(16'h0005), .mr2_value_i(16'h0008), .user_mrs_i(user_mrs_i), .user_bank_i(user_bank_i),
      .user_addr_i(user_addr_i), .busy_o(busy_o), .freq_change_window_o(freq_change_window_o),
      .locked_cmd_ok_o(locked_cmd_ok_o), .done_o(done_o));
   dlfs_dev dlfs_dev_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link), .dll_enabled_o(dll_enabled_o),
      .dll_locked_o(dll_locked_o), .clock_ignored_o(clock_ignored_o), .in_self_refresh_o(in_self_refresh_o),
      .in_power_down_o(in_power_down_o), .mode_zero_o(mode_zero_o), .mode_one_o(mode_one_o));
   dlfs_props dlfs_props_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd(link.cmd), .bank(link.bank),
      .addr(link.addr), .clock_gate_input(link.clock_gate_input),
      .termination_control_pin(link.termination_control_pin), .clk_run(link.clk_run));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Runs one whole sequence and records what crossed the link.
   task automatic run_seq(input logic pd, input logic cal);
      n_entry = 0;
      n_sre = 0;
      n_zq = 0;
      n_mrs = 0;
      t_exit = 0;
      t_mrs1 = 0;
      t_mr0 = 0;
      t_lock = 0;
      cyc = 0;
      mr0_bit8 = 1'b0;
      seen_ign = 1'b0;
      seen_done = 1'b0;
      seen_win = 1'b0;
      seen_sr = 1'b0;
      seen_pd = 1'b0;
      ok_early = 1'b0;
      @(posedge clk_i);
      start_i <= 1'b1;
      use_power_down_i <= pd;
      calibrate_i <= cal;
      @(posedge clk_i);
      start_i <= 1'b0;
      // The device registers the reset a cycle late and then locks, so keep watching past done.
      while ((!seen_done || t_lock == 0) && cyc < 3000) begin
         @(posedge clk_i);
         #1;
         cyc++;
         if (link.cmd === DLFS_CMD_SRE || link.cmd === DLFS_CMD_PDE) n_entry++;
         if (link.cmd === DLFS_CMD_SRE) n_sre++;
         if (link.cmd === DLFS_CMD_SRX || link.cmd === DLFS_CMD_PDX) t_exit = cyc;
         if (link.cmd === DLFS_CMD_LONG_IMPEDANCE_CALIBRATION) n_zq++;
         if (link.cmd === DLFS_CMD_MRS) begin
            if (n_mrs == 0) t_mrs1 = cyc;
            if (n_mrs < 3) bk[n_mrs] = link.bank;
            if (link.bank === 2'h0) begin
               t_mr0 = cyc;
               mr0_bit8 = link.addr[8];
            end
            n_mrs++;
         end
         if (dll_locked_o === 1'b1 && t_lock == 0 && t_mr0 != 0) t_lock = cyc;
         if (clock_ignored_o === 1'b1) seen_ign = 1'b1;
         if (done_o === 1'b1) seen_done = 1'b1;
         if (freq_change_window_o === 1'b1) seen_win = 1'b1;
         if (in_self_refresh_o === 1'b1) seen_sr = 1'b1;
         if (in_power_down_o === 1'b1) seen_pd = 1'b1;
         if (locked_cmd_ok_o === 1'b1 && t_mr0 != 0 && (cyc - t_mr0) < 512) ok_early = 1'b1;
      end
      check("done", seen_done, 1'b1);
      check("entries", n_entry, 16'h0001);
      check("change window", seen_win, 1'b1);
      check("low power state", {seen_sr, seen_pd}, pd ? 2'h1 : 2'h2);
      check("mode set order", {bk[0], bk[1], bk[2]}, {2'h1, 2'h0, 2'h2});
      check("reset bit", mr0_bit8, 1'b1);
      check("reset spacing", (t_mr0 - t_mrs1) >= 4, 1'b1);
      check("lock time", (t_lock - t_mr0) >= 512 && (t_lock - t_mr0) <= 514, 1'b1);
      check("locked ok early", ok_early, 1'b0);
      check("locked ok", locked_cmd_ok_o, 1'b1);
      check("idle again", busy_o, 1'b0);
      check("awake", {in_self_refresh_o, in_power_down_o}, 2'h0);
      check("calibration", n_zq, cal);
      check("loop on", dll_enabled_o, 1'b1);
      check("loop locked", dll_locked_o, 1'b1);
      check("mode one", mode_one_o, 16'h0004);
      check("mode zero", mode_zero_o, 16'h0120);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      check("reset mode one", mode_one_o, 16'h0001);
      check("reset loop", dll_enabled_o, 1'b0);
      check("reset lock", dll_locked_o, 1'b0);
      check("reset busy", busy_o, 1'b0);
      check("reset gate", link.clock_gate_input, 1'b1);
      check("reset term", link.termination_control_pin, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_self_refresh();
      run_seq(1'b0, 1'b1);
      check("self refresh entry", n_sre, 16'h0001);
      check("exit wait", (t_mrs1 - t_exit) >= 17, 1'b1);
      check("clock ignored", seen_ign, 1'b1);
      $display("test self refresh done");
   endtask
   task automatic t_dll_off();
      @(posedge clk_i);
      user_mrs_i <= 1'b1;
      user_bank_i <= 2'h1;
      user_addr_i <= 16'h0005;
      @(posedge clk_i);
      user_addr_i <= 16'h0004;
      @(posedge clk_i);
      user_mrs_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      #1;
      check("off mode one", mode_one_o, 16'h0005);
      check("off loop", dll_enabled_o, 1'b0);
      check("off lock", dll_locked_o, 1'b0);
      $display("test loop off done");
   endtask
   task automatic t_power_down();
      run_seq(1'b1, 1'b0);
      check("no self refresh", n_sre, 16'h0000);
      check("pd exit wait", (t_mrs1 - t_exit) >= 1, 1'b1);
      check("pd clock kept", seen_ign, 1'b0);
      $display("test power down done");
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      #100000;
      errors++;
      end_of_test();
   end
   initial begin
      errors = 0;
      checks = 0;
      reset_n_i = 1'b0;
      start_i = 1'b0;
      use_power_down_i = 1'b0;
      calibrate_i = 1'b0;
      user_mrs_i = 1'b0;
      user_bank_i = 2'h0;
      user_addr_i = 16'h0000;
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      #1;
      t_reset();
      t_self_refresh();
      t_dll_off();
      t_power_down();
      end_of_test();
   end
endmodule
